// ==== rtl/bsm_host.sv ====
// Host controller that sequences the burst supply device through its modes
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module bsm_host #(
  parameter int PorWaitCyc = bsm_pkg::POR_WAIT_CYC
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                clkEn,
  input  wire logic [4:0]          avsAddress,
  input  wire logic                avsRead,
  input  wire logic                avsWrite,
  input  wire logic [31:0]         avsWriteData,
  output      logic [31:0]         avsReadData,
  output      logic                avsWaitRequest,
  output      bsm_pkg::bsm_dreq_s  devReq,
  input  wire bsm_pkg::bsm_dans_s  devAns,
  input  wire logic                readyPin,
  output      logic                loadEnable,
  output      logic                irq
);
  typedef enum logic [3:0] {
    S_POR, S_CFG, S_IDLE, S_SEL, S_VOLT, S_MODE, S_WAIT,
    S_ACT, S_RUN, S_END
  } bsm_state_e;

  bsm_state_e  state_q, state_d;
  logic [31:0] porCnt_q;
  logic [7:0]  pollCnt_q;
  logic [2:0]  cfgIdx_q;
  logic [7:0]  ctrl_q;
  logic [4:0]  irqStat_q, irqMask_q;
  logic [31:0] cfg0_q, cfg1_q;
  logic [7:0]  devStat_q;
  logic        contMode_q, busy_q, inFlight_q, stopReq_q, reContReq_q;
  logic [2:0]  endMode_q;

  // Avalon slave: one-cycle wait on reads gives registered data
  logic rdPend_q;
  assign avsWaitRequest = avsRead & ~rdPend_q;
  wire  wrCtrl  = clkEn & avsWrite & (avsAddress == bsm_pkg::HR_CTRL);
  wire  wrClr   = clkEn & avsWrite & (avsAddress == bsm_pkg::HR_IRQ_STAT);
  wire  wrMask  = clkEn & avsWrite & (avsAddress == bsm_pkg::HR_IRQ_MASK);
  wire  wrCfg0  = clkEn & avsWrite & (avsAddress == bsm_pkg::HR_CFG0);
  wire  wrCfg1  = clkEn & avsWrite & (avsAddress == bsm_pkg::HR_CFG1);
  wire  startOd = wrCtrl & avsWriteData[bsm_pkg::CT_START] & ~busy_q;
  wire  startCm = wrCtrl & avsWriteData[bsm_pkg::CT_CONT] & ~busy_q;
  wire  porDone = (porCnt_q == 32'(PorWaitCyc));

  // Setup write table for min_voltage_and_charge_setup..optimizer_margin
  function automatic logic [7:0] cfgAddr(input logic [2:0] i);
    case (i)
      3'h0:    cfgAddr = bsm_pkg::DEV_MINV;
      3'h1:    cfgAddr = bsm_pkg::DEV_EWARN;
      3'h2:    cfgAddr = bsm_pkg::DEV_CAPMAX;
      default: cfgAddr = bsm_pkg::DEV_OPTMARG;
    endcase
  endfunction : cfgAddr

  wire [7:0] cfgData = cfg0_q[8*cfgIdx_q[1:0] +: 8];
  wire       ansOk   = inFlight_q & devAns.done;
  // Decode a status answer in the cycle it arrives; the held copy is a whole poll old
  wire       ansRd   = ansOk & ~devReq.wr;
  wire [7:0] statNow = ansRd ? devAns.rdata : devStat_q;
  wire       rdyNow  = statNow[bsm_pkg::ST_READY_BIT] | readyPin;
  wire       earlyWarningFlag = statNow[bsm_pkg::ST_EARLY_WARNING_FLAG_BIT];
  wire       alarm   = statNow[bsm_pkg::ST_ALARM_BIT];
  wire       lowBat  = statNow[bsm_pkg::ST_LOWBAT_BIT];
  // In active state the ready pin doubles as early warning
  wire       warnAny = earlyWarningFlag | (state_q == S_RUN & ~readyPin);
  wire       abort   = warnAny | alarm;
  wire [7:0] modeByte = {cfg1_q[15:11], endMode_q};

  wire [4:0] evt;
  assign evt[bsm_pkg::IRQ_READY]  = (state_q == S_WAIT) & rdyNow & ansOk;
  assign evt[bsm_pkg::IRQ_EARLY_WARNING_FLAG] = (state_q == S_RUN) & ansOk & warnAny;
  assign evt[bsm_pkg::IRQ_ALARM]  = (state_q == S_RUN) & ansOk & alarm;
  // Only a fresh status read may raise it, so a cleared bit stays clear
  assign evt[bsm_pkg::IRQ_LOWBAT] = ansRd & lowBat;
  assign evt[bsm_pkg::IRQ_DONE]   = (state_q == S_END) & ansOk;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      S_POR:   if (porDone) state_d = S_CFG;
      S_CFG:   if (ansOk && cfgIdx_q == 3'h3) state_d = S_IDLE;
      S_IDLE:  if (startOd || startCm) state_d = S_SEL;
      S_SEL:   if (ansOk) state_d = S_VOLT;
      S_VOLT:  if (ansOk) state_d = S_MODE;
      S_MODE:  if (ansOk) state_d = S_WAIT;
      S_WAIT:  if (stopReq_q && !inFlight_q) state_d = S_END;
               else if (ansOk && rdyNow) state_d = contMode_q ? S_ACT : S_RUN;
      S_ACT:   if (ansOk) state_d = S_RUN;
      S_RUN:   if (ansOk && abort) state_d = S_END;
               else if (stopReq_q && !inFlight_q) state_d = S_END;
      S_END:   if (ansOk) state_d = S_IDLE;
      default: state_d = S_POR;
    endcase
  end

  // Next device request, issued only when none is outstanding
  bsm_pkg::bsm_dreq_s nextReq;
  always_comb
  begin
    nextReq = '0;
    case (state_q)
      S_CFG:   nextReq = '{1'b1, 1'b1, cfgAddr(cfgIdx_q), cfgData};
      S_SEL:   nextReq = '{1'b1, 1'b1, bsm_pkg::DEV_MODE,
                           {cfg1_q[15:11], bsm_pkg::MODE_STANDBY}};
      S_VOLT:  nextReq = '{1'b1, 1'b1, bsm_pkg::DEV_VOLT, cfg1_q[7:0]};
      S_MODE:  nextReq = '{1'b1, 1'b1, bsm_pkg::DEV_MODE,
                           {cfg1_q[15:11], contMode_q ? bsm_pkg::MODE_CONT
                                                      : bsm_pkg::MODE_ONDEMAND}};
      S_ACT:   nextReq = '{1'b1, 1'b1, bsm_pkg::DEV_MODE,
                           {cfg1_q[15:11], bsm_pkg::MODE_ACTIVE}};
      S_WAIT,
      S_RUN:   nextReq = '{1'b1, 1'b0, bsm_pkg::DEV_STATUS, 8'h00};
      S_END:   nextReq = '{1'b1, 1'b1, bsm_pkg::DEV_MODE, modeByte};
      default: nextReq = '0;
    endcase
  end
  wire pollGap = (state_q == S_WAIT || state_q == S_RUN) && pollCnt_q != 8'h00;
  wire issue   = clkEn & nextReq.req & ~inFlight_q & ~devReq.req & ~pollGap
                 & ~(stopReq_q & (state_q == S_WAIT || state_q == S_RUN));

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= S_POR;
      porCnt_q <= '0;
      pollCnt_q <= '0;
      cfgIdx_q <= '0;
      devReq <= '0;
      inFlight_q <= 1'b0;
      devStat_q <= '0;
      loadEnable <= 1'b0;
    end
    else if (clkEn)
    begin
      state_q <= state_d;
      if (!porDone) porCnt_q <= porCnt_q + 32'h0000_0001;
      if (devReq.req) devReq.req <= 1'b0;
      if (issue)
      begin
        devReq <= nextReq;
        inFlight_q <= 1'b1;
        pollCnt_q <= 8'(bsm_pkg::POLL_GAP_CYC);
      end
      else if (pollCnt_q != 8'h00) pollCnt_q <= pollCnt_q - 8'h01;
      if (ansOk)
      begin
        inFlight_q <= 1'b0;
        if (!devReq.wr) devStat_q <= devAns.rdata;
        if (state_q == S_CFG) cfgIdx_q <= cfgIdx_q + 3'h1;
      end
      if (state_q == S_IDLE) cfgIdx_q <= '0;
      // Load only while the device drives the output in active state
      loadEnable <= (state_d == S_RUN) & ~(ansOk & abort);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctrl_q <= '0;
      irqStat_q <= '0;
      irqMask_q <= '0;
      cfg0_q <= bsm_pkg::CFG0_RST;
      cfg1_q <= bsm_pkg::CFG1_RST;
      contMode_q <= 1'b0;
      busy_q <= 1'b0;
      stopReq_q <= 1'b0;
      reContReq_q <= 1'b0;
      endMode_q <= bsm_pkg::MODE_STANDBY;
      rdPend_q <= 1'b0;
      avsReadData <= '0;
    end
    else if (clkEn)
    begin
      rdPend_q <= avsRead & ~rdPend_q;
      if (avsRead & ~rdPend_q)
      begin
        case (avsAddress)
          bsm_pkg::HR_CTRL:     avsReadData <= {24'h0, ctrl_q};
          bsm_pkg::HR_STATUS:   avsReadData <= {16'h0, devStat_q, 3'h0,
                                                 loadEnable, state_q};
          bsm_pkg::HR_IRQ_STAT: avsReadData <= {27'h0, irqStat_q};
          bsm_pkg::HR_IRQ_MASK: avsReadData <= {27'h0, irqMask_q};
          bsm_pkg::HR_CFG0:     avsReadData <= cfg0_q;
          bsm_pkg::HR_CFG1:     avsReadData <= cfg1_q;
          default:              avsReadData <= '0;
        endcase
      end
      if (wrCtrl) ctrl_q <= avsWriteData[7:0];
      if (wrMask) irqMask_q <= avsWriteData[4:0];
      if (wrCfg0) cfg0_q <= avsWriteData;
      if (wrCfg1) cfg1_q <= avsWriteData;
      // Set wins over the write-one clear
      irqStat_q <= (irqStat_q & ~({5{wrClr}} & avsWriteData[4:0])) | evt;
      if (startOd | startCm)
      begin
        busy_q <= 1'b1;
        contMode_q <= startCm;
        stopReq_q <= 1'b0;
        reContReq_q <= 1'b0;
        endMode_q <= bsm_pkg::MODE_STANDBY;
      end
      else if (wrCtrl && busy_q && avsWriteData[bsm_pkg::CT_STOP])
      begin
        stopReq_q <= 1'b1;
        reContReq_q <= avsWriteData[bsm_pkg::CT_RECONT] & contMode_q;
      end
      if (state_q == S_RUN && state_d == S_END)
        endMode_q <= (reContReq_q && !abort) ? bsm_pkg::MODE_CONT
                                             : bsm_pkg::MODE_STANDBY;
      else if (state_q == S_WAIT && state_d == S_END)
        endMode_q <= bsm_pkg::MODE_STANDBY;
      if (state_q == S_END && ansOk)
      begin
        busy_q <= 1'b0;
        stopReq_q <= 1'b0;
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  property p_porQuiet;
    @(posedge clk) disable iff (rst) !porDone |-> !devReq.req;
  endproperty
  a_porQuiet: assert property (p_porQuiet)
    else $error("device accessed before power-on wait");

  property p_abortEnd;
    @(posedge clk) disable iff (rst)
      (clkEn && state_q == S_RUN && ansOk && abort) |=> state_q == S_END;
  endproperty
  a_abortEnd: assert property (p_abortEnd)
    else $error("warning or alarm did not end cycle");

  property p_loadOff;
    @(posedge clk) disable iff (rst)
      (clkEn && state_q == S_RUN && ansOk && alarm) |=> !loadEnable;
  endproperty
  a_loadOff: assert property (p_loadOff)
    else $error("load kept on after alarm");

  property p_loadOnlyRun;
    @(posedge clk) disable iff (rst) loadEnable |-> state_q == S_RUN;
  endproperty
  a_loadOnlyRun: assert property (p_loadOnlyRun)
    else $error("load enabled outside active");

  property p_actAfterRdy;
    @(posedge clk) disable iff (rst)
      (state_q == S_ACT && $changed(state_q)) |-> $past(state_q) == S_WAIT && contMode_q;
  endproperty
  a_actAfterRdy: assert property (p_actAfterRdy)
    else $error("active write without ready in continuous");

  property p_cfgOrder;
    @(posedge clk) disable iff (rst)
      (devReq.req && state_q == S_CFG) |-> devReq.addr == cfgAddr(cfgIdx_q);
  endproperty
  a_cfgOrder: assert property (p_cfgOrder)
    else $error("setup write to wrong register");

  property p_endStandby;
    @(posedge clk) disable iff (rst)
      (devReq.req && state_q == S_END && !reContReq_q) |-> devReq.wdata[2:0] == 3'h0;
  endproperty
  a_endStandby: assert property (p_endStandby)
    else $error("standby write not 000b");

  property p_lowBatNoStop;
    @(posedge clk) disable iff (rst)
      (clkEn && state_q == S_RUN && ansOk && lowBat && !abort && !stopReq_q)
        |=> state_q == S_RUN;
  endproperty
  a_lowBatNoStop: assert property (p_lowBatNoStop)
    else $error("low battery ended cycle");

  // A ready answer must be acted on at once, not one poll later
  property p_readyFresh;
    @(posedge clk) disable iff (rst)
      (clkEn && state_q == S_WAIT && ansRd && devAns.rdata[bsm_pkg::ST_READY_BIT])
        |=> state_q != S_WAIT;
  endproperty
  a_readyFresh: assert property (p_readyFresh)
    else $error("ready answer did not end the charge wait");

  property p_stopEnd;
    @(posedge clk) disable iff (rst)
      (clkEn && stopReq_q && !inFlight_q && (state_q == S_WAIT || state_q == S_RUN))
        |=> state_q == S_END;
  endproperty
  a_stopEnd: assert property (p_stopEnd)
    else $error("stop request did not end the cycle");

  c_ondemand: cover property (@(posedge clk) state_q == S_RUN && !contMode_q);
  c_cont: cover property (@(posedge clk) state_q == S_ACT);
  c_abort: cover property (@(posedge clk)
    state_q == S_RUN && ansOk && abort ##1 state_q == S_END);
  c_lowBat: cover property (@(posedge clk) state_q == S_RUN && ansRd && lowBat);
  c_reCont: cover property (@(posedge clk)
    state_q == S_END && endMode_q == bsm_pkg::MODE_CONT);
endmodule : bsm_host

// ==== rtl/bsm_pkg.sv ====
// Package for the burst supply mode sequencer host controller
package bsm_pkg;
  // Device register map (reached through the device's own serial port)
  localparam logic [7:0] DEV_STATUS     = 8'h00;
  localparam logic [7:0] DEV_MODE       = 8'h08;
  localparam logic [7:0] DEV_VOLT       = 8'h09;
  localparam logic [7:0] DEV_MINV       = 8'h0A;
  localparam logic [7:0] DEV_EWARN      = 8'h0B;
  localparam logic [7:0] DEV_CAPMAX     = 8'h0C;
  localparam logic [7:0] DEV_OPTMARG    = 8'h0D;
  // Status bit positions in the device status register
  localparam int         ST_READY_BIT   = 0;
  localparam int         ST_EARLY_WARNING_FLAG_BIT = 1;
  localparam int         ST_ALARM_BIT   = 2;
  localparam int         ST_LOWBAT_BIT  = 3;
  // Mode field values
  localparam logic [2:0] MODE_STANDBY   = 3'h0;
  localparam logic [2:0] MODE_ONDEMAND  = 3'h1;
  localparam logic [2:0] MODE_CONT      = 3'h2;
  localparam logic [2:0] MODE_ACTIVE    = 3'h4;
  // Host-side register byte addresses (Avalon)
  localparam logic [4:0] HR_CTRL        = 5'h00;
  localparam logic [4:0] HR_STATUS      = 5'h04;
  localparam logic [4:0] HR_IRQ_STAT    = 5'h08;
  localparam logic [4:0] HR_IRQ_MASK    = 5'h0C;
  localparam logic [4:0] HR_CFG0        = 5'h10;
  localparam logic [4:0] HR_CFG1        = 5'h14;
  // Control bits
  localparam int         CT_START       = 0;
  localparam int         CT_CONT        = 1;
  localparam int         CT_STOP        = 2;
  localparam int         CT_RECONT      = 3;
  localparam int         CT_USEPROF     = 4;
  // Interrupt bits
  localparam int         IRQ_READY      = 0;
  localparam int         IRQ_EARLY_WARNING_FLAG = 1;
  localparam int         IRQ_ALARM      = 2;
  localparam int         IRQ_LOWBAT     = 3;
  localparam int         IRQ_DONE       = 4;
  // Timing
  localparam int         CLK_MHZ        = 125;
  localparam int         POR_WAIT_MS    = 20;
  localparam int         POR_WAIT_CYC   = POR_WAIT_MS * 1000 * CLK_MHZ;
  localparam int         POLL_GAP_CYC   = 64;
  // Reset defaults of host copies of device settings
  localparam logic [31:0] CFG0_RST      = 32'h0000_0000;
  localparam logic [31:0] CFG1_RST      = 32'h0000_0000;

  typedef struct packed {
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } bsm_dreq_s;

  typedef struct packed {
    logic       done;
    logic [7:0] rdata;
  } bsm_dans_s;
endpackage : bsm_pkg

// ==== testbench/bsm_dev_model.sv ====
// Behavioural model of the burst supply device as seen through its serial port
`timescale 1ns/1ps
module bsm_dev_model #(
  parameter int         ChgCyc  = 40,
  parameter logic [7:0] VoltRst = 8'h00
) (
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire bsm_pkg::bsm_dreq_s devReq,
  output      bsm_pkg::bsm_dans_s devAns,
  output      logic               readyPin,
  input  wire logic [3:0]         ansDelay,
  input  wire logic               earlyWarningFlagIn,
  input  wire logic               alarmIn,
  input  wire logic               lowBatIn,
  output      logic [15:0]        firstAcc
);
  logic [7:0]         regs [0:15];
  logic               rdy;
  logic               seen;
  int                 chg;
  int                 pend;
  bsm_pkg::bsm_dreq_s cur;
  wire  [7:0]         status = {4'h0, lowBatIn, alarmIn, earlyWarningFlagIn,
                                rdy};
  // Early warning pulls the ready pin low so the host may watch the pin alone
  assign readyPin = rdy & ~earlyWarningFlagIn;
  always @(posedge clk)
  begin
    if (rst)
    begin
      foreach (regs[i]) regs[i] <= 8'h00;
      regs[9] <= VoltRst;
      rdy <= 1'b0;
      chg <= 0;
      pend <= 0;
      seen <= 1'b0;
      firstAcc <= 16'h0000;
      devAns <= '0;
    end
    else
    begin
      firstAcc <= seen ? firstAcc : firstAcc + 16'h0001;
      if (devReq.req)
        seen <= 1'b1;
      if (chg == 1)
        rdy <= 1'b1;
      if (chg > 0)
        chg <= chg - 1;
      devAns.done <= 1'b0;
      // Released data line toggles so a stale capture cannot pass
      devAns.rdata <= ~devAns.rdata;
      if (devReq.req && pend == 0)
      begin
        cur <= devReq;
        pend <= int'(ansDelay) + 1;
      end
      if (pend > 0)
        pend <= pend - 1;
      if (pend == 1)
      begin
        devAns.done <= 1'b1;
        devAns.rdata <= (cur.addr == 8'h00) ? status : regs[cur.addr[3:0]];
        if (cur.wr)
          regs[cur.addr[3:0]] <= cur.wdata;
        if (cur.wr && cur.addr == 8'h08 && cur.wdata[2:0] != 3'h4)
        begin
          // Mode writes act at once; standby aborts, charge modes restart
          rdy <= 1'b0;
          chg <= (cur.wdata[2:0] == 3'h0) ? 0 : ChgCyc;
        end
      end
    end
  end
endmodule : bsm_dev_model

// ==== testbench/bsm_host_bench.sv ====
// Self-checking bench of the host controller against the device model
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_compared++; if ((gt) !== (ex)) begin n_mismatch++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module bsm_host_bench;
  localparam int PorW = 50;
  logic               clk = 1'b0;
  logic               rst = 1'b1;
  logic [4:0]         avsAddress = 5'h00;
  logic               avsRead = 1'b0;
  logic               avsWrite = 1'b0;
  logic [31:0]        avsWriteData = 32'h0000_0000;
  logic [31:0]        avsReadData;
  logic               avsWaitRequest;
  bsm_pkg::bsm_dreq_s devReq;
  bsm_pkg::bsm_dans_s devAns;
  logic               readyPin;
  logic               loadEnable;
  logic               irq;
  logic [3:0]         ansDelay = 4'h0;
  logic               earlyWarningFlagIn = 1'b0;
  logic               clkEn = 1'b1;
  logic               alarmIn = 1'b0;
  logic               lowBatIn = 1'b0;
  logic [15:0]        firstAcc;
  logic [31:0]        cfg0;
  logic [31:0]        cfg1;
  logic [31:0]        rd;
  int                 n_mismatch = 0;
  int                 n_compared = 0;
  initial forever #4 clk = ~clk;
  bsm_host #(.PorWaitCyc(PorW)) uut (.clk(clk), .rst(rst), .clkEn(clkEn),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .devReq(devReq), .devAns(devAns),
    .readyPin(readyPin), .loadEnable(loadEnable), .irq(irq));
  bsm_dev_model dev (.clk(clk), .rst(rst), .devReq(devReq), .devAns(devAns),
    .readyPin(readyPin), .ansDelay(ansDelay),
    .earlyWarningFlagIn(earlyWarningFlagIn), .alarmIn(alarmIn),
    .lowBatIn(lowBatIn), .firstAcc(firstAcc));
  task automatic avAcc(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsWrite <= wr;
    avsRead <= ~wr;
    do @(posedge clk); while (avsWaitRequest !== 1'b0);
    rd = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask : avAcc
  // Bounded wait for a condition, then one compare of its final value
  task automatic waitEq(input string nm, input logic [7:0] ex, ref logic [7:0] gt);
    for (int i = 0; i < 3000 && gt !== ex; i++) @(posedge clk);
    `CHK(nm, ex, gt)
  endtask : waitEq
  function automatic logic [7:0] cfgByte(input logic [31:0] w, input int i);
    return w[8*i +: 8];
  endfunction : cfgByte
  logic [7:0] modeNow;
  logic [7:0] loadNow;
  always @(posedge clk) modeNow <= {5'h00, dev.regs[8][2:0]};
  always @(posedge clk) loadNow <= {7'h00, loadEnable};
  task automatic runCycle(input logic cont, input logic [1:0] fault);
    cfg1 = $urandom;
    ansDelay <= 4'($urandom % 8);
    avAcc(1'b1, bsm_pkg::HR_CFG1, cfg1);
    avAcc(1'b1, bsm_pkg::HR_CTRL, cont ? 32'h0000_0002 : 32'h0000_0001);
    waitEq("loadOn", 8'h01, loadNow);
    `CHK("mode", cont ? bsm_pkg::MODE_ACTIVE : bsm_pkg::MODE_ONDEMAND, dev.regs[8][2:0])
    `CHK("vset", cfg1[7:0], dev.regs[9])
    `CHK("rdyPin", 1'b1, readyPin)
    avAcc(1'b0, bsm_pkg::HR_STATUS, 32'h0);
    `CHK("stLoad", 1'b1, rd[4])
    if (fault == 2'd1) earlyWarningFlagIn <= 1'b1;
    if (fault == 2'd2) alarmIn <= 1'b1;
    if (fault == 2'd3) lowBatIn <= 1'b1;
    if (fault == 2'd1 || fault == 2'd2)
    begin
      waitEq("faultOff", 8'h00, loadNow);
      waitEq("faultMode", 8'h00, modeNow);
    end
    else
    begin
      repeat (300) @(posedge clk);
      `CHK("lowBatLoad", 1'b1, loadEnable)
      avAcc(1'b1, bsm_pkg::HR_CTRL, cont ? 32'h0000_000C : 32'h0000_0004);
      waitEq("stopOff", 8'h00, loadNow);
      waitEq("stopMode", cont ? 8'h02 : 8'h00, modeNow);
    end
    avAcc(1'b0, bsm_pkg::HR_IRQ_STAT, 32'h0);
    `CHK("irqBits", {fault == 2'd3, fault == 2'd2, fault == 2'd1, 1'b1}, rd[3:0])
    earlyWarningFlagIn <= 1'b0;
    alarmIn <= 1'b0;
    lowBatIn <= 1'b0;
    avAcc(1'b1, bsm_pkg::HR_IRQ_STAT, 32'h0000_001F);
    repeat (2) avAcc(1'b1, bsm_pkg::HR_CTRL, 32'h0000_0004);
    repeat (200) @(posedge clk);
  endtask : runCycle
  initial
  begin
    void'($urandom(32'h7d5b));
    cfg0 = $urandom;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    avAcc(1'b1, bsm_pkg::HR_CFG0, cfg0);
    avAcc(1'b0, 5'h1C, 32'h0);
    `CHK("unmapped", 32'h0000_0000, rd)
    avAcc(1'b0, bsm_pkg::HR_IRQ_MASK, 32'h0);
    `CHK("maskRst", 32'h0000_0000, rd)
    repeat (PorW + 400) @(posedge clk);
    `CHK("porWait", 1'b1, firstAcc >= 16'(PorW))
    for (int i = 0; i < 4; i++) `CHK("setup", cfgByte(cfg0, i), dev.regs[10 + i])
    for (int i = 0; i < 8; i++) runCycle(i[0], i[2:1]);
    avAcc(1'b1, bsm_pkg::HR_CTRL, 32'h0000_0001);
    // Frozen right after the start: without the freeze the load would be on well before
    clkEn <= 1'b0;
    repeat (200) @(posedge clk);
    `CHK("frozen", 8'h00, loadNow)
    clkEn <= 1'b1;
    waitEq("loadOn2", 8'h01, loadNow);
    avAcc(1'b1, bsm_pkg::HR_IRQ_MASK, 32'h0000_0000);
    @(posedge clk);
    `CHK("irqMasked", 1'b0, irq)
    avAcc(1'b1, bsm_pkg::HR_IRQ_MASK, 32'h0000_001F);
    @(posedge clk);
    `CHK("irqOpen", 1'b1, irq)
    avAcc(1'b1, bsm_pkg::HR_CTRL, 32'h0000_0004);
    waitEq("abortMode", 8'h00, modeNow);
    repeat (300) @(posedge clk);
    avAcc(1'b1, bsm_pkg::HR_IRQ_STAT, 32'h0000_001F);
    @(posedge clk);
    `CHK("irqClear", 1'b0, irq)
    results();
  end
  initial
  begin
    repeat (90000) @(posedge clk);
    n_mismatch++;
    results();
  end
  task automatic results();
    $display("Compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : results
endmodule : bsm_host_bench
